/* core/rrc_pkg.sv */
// Package with constants and types for the regulator reset control block.
package rrc_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned POR_HOLD_MS = 110;
  localparam int unsigned POR_HOLD_CYCLES = (POR_HOLD_MS * (CLK_HZ / 1000));
  localparam int unsigned DISCHARGE_MS = 10;
  localparam int unsigned DISCHARGE_CYCLES = (DISCHARGE_MS * (CLK_HZ / 1000));
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef enum logic [1:0] {
    RRC_POR_HOLD = 2'b00,
    RRC_RUN = 2'b01
  } rrc_state_t;

  typedef struct packed {
    logic wireless_power_enable;
    logic app_cpu_power_enable;
  } rrc_enables_t;

  typedef struct packed {
    logic regulator_enable;
    logic wireless_reset;
    logic app_cpu_reset;
  } rrc_controls_t;
endpackage : rrc_pkg

/* core/rrc_top.sv */
// Regulator enable and section reset control driven by the two host power enables.
//
// Operation
// - Regulators on when either synchronised enable is high; off only when both are low.
// - Wireless section in reset while its enable is low, released while high.
// - Application section in reset while its enable is low, whatever the wireless enable.
// - Power-on reset holds the device no longer than 110 ms after supplies valid.
`timescale 1ns/1ps
module rrc_top #(
  parameter int unsigned POR_HOLD_CYCLES = rrc_pkg::POR_HOLD_CYCLES
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Supply status.
  input wire logic core_supply_good_i,
  input wire logic io_supply_good_i,
  // Host power enables.
  input wire rrc_pkg::rrc_enables_t enables_i,
  // Controls toward the regulators and sections.
  output rrc_pkg::rrc_controls_t controls_o,
  output logic por_active_o
);
  // Synchronised host enables.
  logic wl_synced;
  logic app_synced;
  // Power-on reset sequencing.
  rrc_pkg::rrc_state_t state;
  rrc_pkg::rrc_state_t next_state;
  logic [31:0] por_count;
  logic [31:0] next_por_count;
  logic supplies_good;
  logic hold_done;
  // Output registers and their next values.
  logic regulator_enable;
  logic next_regulator_enable;
  logic wireless_reset;
  logic next_wireless_reset;
  logic app_cpu_reset;
  logic next_app_cpu_reset;
  logic por_active;
  logic next_por_active;

  // Both supply monitors must agree before the hold may count.
  assign supplies_good = core_supply_good_i & io_supply_good_i;
  assign hold_done = (por_count >= POR_HOLD_CYCLES - 32'h1);

  // Each enable gets its own two-stage synchroniser.
  rrc_sync_pair #(
    .RESET_VALUE(rrc_pkg::SYNC_RESET)
  ) wl_sync_i (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .async_i(enables_i.wireless_power_enable),
    .sync_o(wl_synced)
  );

  rrc_sync_pair #(
    .RESET_VALUE(rrc_pkg::SYNC_RESET)
  ) app_sync_i (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .async_i(enables_i.app_cpu_power_enable),
    .sync_o(app_synced)
  );

  // The hold counts from the moment both supplies are valid; a supply drop restarts it.
  always_comb begin
    next_state = state;
    next_por_count = por_count;
    case (state)
      rrc_pkg::RRC_POR_HOLD: begin
        if (!supplies_good) begin
          next_por_count = 32'h0;
        end else if (hold_done) begin
          next_state = rrc_pkg::RRC_RUN;
          next_por_count = 32'h0;
        end else begin
          next_por_count = por_count + 32'h1;
        end
      end
      rrc_pkg::RRC_RUN: begin
        if (!supplies_good) begin
          next_state = rrc_pkg::RRC_POR_HOLD;
        end
      end
      default: begin
        next_state = rrc_pkg::RRC_POR_HOLD;
        next_por_count = 32'h0;
      end
    endcase
  end

  // Sequencing state registers.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state <= rrc_pkg::RRC_POR_HOLD;
      por_count <= 32'h0;
    end else begin
      state <= next_state;
      por_count <= next_por_count;
    end
  end

  // The regulator enable follows the synchronised levels only, so no history of delays matters.
  always_comb begin
    next_regulator_enable = 1'b0;
    if (wl_synced) begin
      next_regulator_enable = 1'b1;
    end else if (app_synced) begin
      next_regulator_enable = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      regulator_enable <= 1'b0;
    end else begin
      regulator_enable <= next_regulator_enable;
    end
  end

  // The hold flag leads the section resets so both move on the same edge.
  always_comb begin
    next_por_active = 1'b0;
    if (next_state == rrc_pkg::RRC_POR_HOLD) begin
      next_por_active = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      por_active <= 1'b1;
    end else begin
      por_active <= next_por_active;
    end
  end

  // The wireless section stays in reset while the hold runs or its enable is low.
  always_comb begin
    next_wireless_reset = 1'b1;
    if (next_por_active) begin
      next_wireless_reset = 1'b1;
    end else if (wl_synced) begin
      next_wireless_reset = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wireless_reset <= 1'b1;
    end else begin
      wireless_reset <= next_wireless_reset;
    end
  end

  // With the wireless enable low the app section follows its own enable alone.
  always_comb begin
    next_app_cpu_reset = 1'b1;
    if (next_por_active) begin
      next_app_cpu_reset = 1'b1;
    end else if (app_synced) begin
      next_app_cpu_reset = 1'b0;
    end else if (wl_synced) begin
      next_app_cpu_reset = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      app_cpu_reset <= 1'b1;
    end else begin
      app_cpu_reset <= next_app_cpu_reset;
    end
  end

  // Drive the packed outputs straight from the flip-flops.
  always_comb begin
    controls_o.regulator_enable = regulator_enable;
    controls_o.wireless_reset = wireless_reset;
    controls_o.app_cpu_reset = app_cpu_reset;
  end

  assign por_active_o = por_active;
endmodule : rrc_top

// Two-stage synchroniser for one asynchronous level.
module rrc_sync_pair #(
  parameter logic [1:0] RESET_VALUE = rrc_pkg::SYNC_RESET
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Level in and out.
  input wire logic async_i,
  output logic sync_o
);
  logic [1:0] stages;
  logic [1:0] next_stages;
  // A metastable first stage gets a full cycle to settle before stage two passes it on.

  // Stage one is read only by stage two.
  always_comb begin
    next_stages = {stages[0], async_i};
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      stages <= RESET_VALUE;
    end else begin
      stages <= next_stages;
    end
  end

  assign sync_o = stages[1];
endmodule : rrc_sync_pair

/* sim/rrc_host_model.sv */
// Host model that drives the two power enables.
`timescale 1ns/1ps
module rrc_host_model #(parameter int WAIT = rrc_pkg::DISCHARGE_CYCLES) (
  input wire logic sys_clk_i,
  input wire rrc_pkg::rrc_enables_t want_i,
  output rrc_pkg::rrc_enables_t enables_o = '0
);
  int idle = 0;
  always @(posedge sys_clk_i) begin
    idle <= (enables_o == '0) ? idle + 1 : 0;
    if (enables_o != '0 || idle >= WAIT) enables_o <= want_i;
  end
endmodule : rrc_host_model

/* sim/rrc_top_props.sv */
// Checker for the regulator reset control block.
`timescale 1ns/1ps
module rrc_top_props (
  input wire logic sys_clk_i, reset_i, core_supply_good_i, io_supply_good_i, por_active_o,
  input wire rrc_pkg::rrc_enables_t enables_i,
  input wire rrc_pkg::rrc_controls_t controls_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  reg_follow_a: assert property ((!reset_i)[*4] |->
    controls_o.regulator_enable == |$past(enables_i, 3)) else $error("regulator enable wrong");
  wl_reset_a: assert property ((!reset_i)[*4] ##0 (!por_active_o)[*2] |->
    controls_o.wireless_reset == !$past(enables_i.wireless_power_enable, 3)) else $error("wireless reset wrong");
  app_reset_a: assert property ((!reset_i)[*4] ##0 (!por_active_o)[*2] ##0
    $past(enables_i.wireless_power_enable, 3) |-> controls_o.app_cpu_reset == !$past(enables_i.app_cpu_power_enable, 3))
    else $error("app reset wrong");
  por_resets_a: assert property (por_active_o[*2] |->
    controls_o.wireless_reset && controls_o.app_cpu_reset) else $error("reset not held");
  supply_drop_a: assert property (!(core_supply_good_i && io_supply_good_i) |=> por_active_o)
    else $error("hold not entered on supply drop");
endmodule : rrc_top_props
bind rrc_top rrc_top_props rrc_top_props_i (.*);

/* sim/tb_regulator_reset_control.sv */
// Testbench for the regulator reset control block.
`timescale 1ns/1ps
module tb_regulator_reset_control;
  logic sys_clk_i = 0, reset_i = 1, core_ok = 1, io_ok = 1, por;
  rrc_pkg::rrc_enables_t want = '0, en;
  rrc_pkg::rrc_controls_t ctl;
  int err_total = 0, comparisons = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  rrc_top #(.POR_HOLD_CYCLES(20)) rrc_top_i (.sys_clk_i, .reset_i, .core_supply_good_i(core_ok),
    .io_supply_good_i(io_ok), .enables_i(en), .controls_o(ctl), .por_active_o(por));
  rrc_host_model #(.WAIT(12)) rrc_host_model_i (.sys_clk_i, .want_i(want), .enables_o(en));
  task wait_n(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : wait_n
  task chk(input string n, input logic [3:0] s, e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task complete_run;
    $display("errors %0d checks %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task por_cycle;
    chk("por on", {por, ctl}, 4'hb);
    wait_n(22);
    chk("por off", {por, ctl}, 4'h3);
  endtask : por_cycle
  task combos;
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk_i) want <= i[1:0];
      wait_n(10);
      chk("controls", {1'b0, ctl}, {1'b0, |want, ~want});
    end
  endtask : combos
  initial begin
    wait_n(300);
    err_total++;
    complete_run();
  end
  initial begin
    wait_n(3);
    @(posedge sys_clk_i) reset_i <= 0;
    wait_n(1);
    por_cycle();
    @(posedge sys_clk_i) io_ok <= 0;
    wait_n(3);
    @(posedge sys_clk_i) io_ok <= 1;
    wait_n(1);
    por_cycle();
    combos();
    complete_run();
  end
endmodule : tb_regulator_reset_control
